// ---- hw/ctd_map.svh ----
// Opcode, field, width and reset constants of the instruction timing decoder
`ifndef CTD_MAP_SVH
`define CTD_MAP_SVH
// ----------------------------------------
// Opcodes, exact
// ----------------------------------------
`define CTD_OP_NOP 8'h00
`define CTD_OP_UNUSED 8'ha5
`define CTD_OP_CLRA 8'he4
`define CTD_OP_CPLA 8'hf4
`define CTD_OP_RLA 8'h23
`define CTD_OP_RLCA 8'h33
`define CTD_OP_RRA 8'h03
`define CTD_OP_RRCA 8'h13
`define CTD_OP_SWAPA 8'hc4
`define CTD_OP_MOVDD 8'h85
`define CTD_OP_LOADDP 8'h90
`define CTD_OP_CODEDP 8'h93
`define CTD_OP_CODEPC 8'h83
`define CTD_OP_EXTRDDP 8'he0
`define CTD_OP_EXTWRDP 8'hf0
`define CTD_OP_PUSH 8'hc0
`define CTD_OP_POP 8'hd0
`define CTD_OP_ANLCB 8'h82
`define CTD_OP_ANLCNB 8'hb0
`define CTD_OP_ORLCB 8'h72
`define CTD_OP_ORLCNB 8'ha0
`define CTD_OP_JZ 8'h60
`define CTD_OP_JNZ 8'h70
`define CTD_OP_JC 8'h40
`define CTD_OP_JNC 8'h50
`define CTD_OP_JB 8'h20
`define CTD_OP_JNB 8'h30
`define CTD_OP_BITCLR 8'h10
`define CTD_OP_CMPAD 8'hb5
`define CTD_OP_CMPAI 8'hb4
`define CTD_OP_DECDIR 8'hd5
`define CTD_OP_SHORTJ 8'h80
`define CTD_OP_INDJMP 8'h73
`define CTD_OP_LONGCALL 8'h12
`define CTD_OP_LONGJUMP 8'h02
`define CTD_OP_XRLDI 8'h63
// ----------------------------------------
// Opcode families, upper bits only, plus the page form matched on the low four bits
// ----------------------------------------
`define CTD_HI5_MOVARN 5'h1d
`define CTD_HI5_CMPRN 5'h17
`define CTD_HI5_DECRN 5'h1b
`define CTD_HI7_MOVAIND 7'h73
`define CTD_HI7_EXTRDI 7'h71
`define CTD_HI7_EXTWRI 7'h79
`define CTD_HI7_NIBXCH 7'h6b
`define CTD_HI7_CMPIND 7'h5b
`define CTD_LO4_PAGE 4'h1
// ----------------------------------------
// Lengths, cycle counts and fields
// ----------------------------------------
`define CTD_LEN1 2'h1
`define CTD_LEN2 2'h2
`define CTD_LEN3 2'h3
`define CTD_CYC1 3'h1
`define CTD_CYC2 3'h2
`define CTD_CYC3 3'h3
`define CTD_CYC4 3'h4
`define CTD_SFR_BIT 7
`define CTD_PAGE_LSB 11
`define CTD_RST_ADDR 16'h0000
`define CTD_RST_BYTE 8'h00
`define CTD_RST_CYC 3'h0
`define CTD_RST_LEN 2'h0
`endif

// ---- hw/ctd_pkg.sv ----
// Types shared by the instruction timing decoder files
package ctd_pkg;
	typedef enum logic [2:0] {
		KIND_PLAIN, KIND_COND, KIND_BITCLR, KIND_SHORT, KIND_PAGE, KIND_LONG, KIND_INDJMP
	} ctd_kind_type;
	typedef enum logic [1:0] {REG_NONE, REG_BANK, REG_IND} ctd_reg_type;
	typedef enum logic {ST_IDLE, ST_EXEC} ctd_state_type;
endpackage

// ---- hw/ctd_op_table.sv ----
// Opcode table: length, base cycles and operand kind of each instruction
`timescale 1ns/1ps
`include "ctd_map.svh"
module ctd_op_table
	import ctd_pkg::*;
(
	// Opcode in
	input wire logic [7:0] opcode,
	// Decoded attributes
	output ctd_kind_type kind,
	output ctd_reg_type regMode,
	output logic [1:0] len,
	output logic [2:0] cyc,
	output logic usesDirect,
	output logic relInByte2,
	output logic nibbleOnly,
	output logic carryOp
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Unlisted opcodes fall to one byte, one cycle; the unused code is a plain no-op
	always_comb begin
		kind = KIND_PLAIN;
		regMode = REG_NONE;
		len = `CTD_LEN1;
		cyc = `CTD_CYC1;
		usesDirect = 1'b0;
		relInByte2 = 1'b0;
		nibbleOnly = 1'b0;
		carryOp = 1'b0;
		if (opcode[7:3] == `CTD_HI5_MOVARN) begin
			regMode = REG_BANK;
		end else if (opcode[7:3] == `CTD_HI5_CMPRN) begin
			kind = KIND_COND;
			regMode = REG_BANK;
			len = `CTD_LEN3;
			cyc = `CTD_CYC3;
			relInByte2 = 1'b1;
		end else if (opcode[7:3] == `CTD_HI5_DECRN) begin
			kind = KIND_COND;
			regMode = REG_BANK;
			len = `CTD_LEN2;
			cyc = `CTD_CYC2;
		end else if (opcode[7:1] == `CTD_HI7_MOVAIND) begin
			regMode = REG_IND;
			cyc = `CTD_CYC2;
		end else if (opcode[7:1] == `CTD_HI7_EXTRDI || opcode[7:1] == `CTD_HI7_EXTWRI) begin
			regMode = REG_IND;
			cyc = `CTD_CYC3;
		end else if (opcode[7:1] == `CTD_HI7_NIBXCH) begin
			regMode = REG_IND;
			cyc = `CTD_CYC2;
			nibbleOnly = 1'b1;
		end else if (opcode[7:1] == `CTD_HI7_CMPIND) begin
			kind = KIND_COND;
			regMode = REG_IND;
			len = `CTD_LEN3;
			cyc = `CTD_CYC4;
			relInByte2 = 1'b1;
		end else if (opcode[3:0] == `CTD_LO4_PAGE) begin
			kind = KIND_PAGE;
			len = `CTD_LEN2;
			cyc = `CTD_CYC3;
		end else begin
			case (opcode)
				`CTD_OP_MOVDD, `CTD_OP_XRLDI: begin
					len = `CTD_LEN3;
					cyc = `CTD_CYC3;
					usesDirect = 1'b1;
				end
				`CTD_OP_LOADDP: begin
					len = `CTD_LEN3;
					cyc = `CTD_CYC3;
				end
				`CTD_OP_CODEDP, `CTD_OP_CODEPC, `CTD_OP_EXTRDDP, `CTD_OP_EXTWRDP: begin
					cyc = `CTD_CYC3;
				end
				`CTD_OP_PUSH, `CTD_OP_POP: begin
					len = `CTD_LEN2;
					cyc = `CTD_CYC2;
					usesDirect = 1'b1;
				end
				`CTD_OP_ANLCB, `CTD_OP_ANLCNB, `CTD_OP_ORLCB, `CTD_OP_ORLCNB: begin
					len = `CTD_LEN2;
					cyc = `CTD_CYC2;
					carryOp = 1'b1;
				end
				`CTD_OP_JZ, `CTD_OP_JNZ, `CTD_OP_JC, `CTD_OP_JNC: begin
					kind = KIND_COND;
					len = `CTD_LEN2;
					cyc = `CTD_CYC2;
				end
				`CTD_OP_JB, `CTD_OP_JNB, `CTD_OP_BITCLR: begin
					kind = (opcode == `CTD_OP_BITCLR) ? KIND_BITCLR : KIND_COND;
					len = `CTD_LEN3;
					cyc = `CTD_CYC3;
					relInByte2 = 1'b1;
				end
				`CTD_OP_CMPAD, `CTD_OP_DECDIR: begin
					kind = KIND_COND;
					len = `CTD_LEN3;
					cyc = `CTD_CYC3;
					relInByte2 = 1'b1;
					usesDirect = 1'b1;
				end
				`CTD_OP_CMPAI: begin
					kind = KIND_COND;
					len = `CTD_LEN3;
					cyc = `CTD_CYC3;
					relInByte2 = 1'b1;
				end
				`CTD_OP_SHORTJ: begin
					kind = KIND_SHORT;
					len = `CTD_LEN2;
					cyc = `CTD_CYC3;
				end
				`CTD_OP_INDJMP: begin
					kind = KIND_INDJMP;
					cyc = `CTD_CYC3;
				end
				`CTD_OP_LONGCALL, `CTD_OP_LONGJUMP: begin
					kind = KIND_LONG;
					len = `CTD_LEN3;
					cyc = `CTD_CYC4;
				end
				default: begin
					kind = KIND_PLAIN;
				end
			endcase
		end
	end
endmodule

// ---- hw/ctd_timing_decoder.sv ----
// Instruction timing decoder: cycle counter, branch targets and operand decode
`timescale 1ns/1ps
`include "ctd_map.svh"
module ctd_timing_decoder
	import ctd_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Instruction presented by the fetch unit
	input wire logic opValid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] operand1,
	input wire logic [7:0] operand2,
	input wire logic [15:0] instrAddr,
	// Datapath state
	input wire logic condTrue,
	input wire logic [1:0] bankSel,
	input wire logic [7:0] accValue,
	input wire logic [15:0] dataPointer,
	input wire logic carryIn,
	input wire logic bitValue,
	// Sequencing
	output logic opReady,
	output logic busy,
	output logic instrDone,
	output logic [2:0] cycleIndex,
	output logic [2:0] instrCycles,
	output logic [1:0] instrLen,
	// Flow control
	output logic branchTaken,
	output logic targetValid,
	output logic [15:0] targetAddr,
	output logic [15:0] nextAddr,
	// Operand decode
	output logic directValid,
	output logic directIsSfr,
	output logic regAddrValid,
	output logic [7:0] regAddr,
	output logic nibbleOnly,
	output logic clearBit,
	output logic carryWrite,
	output logic carryOut
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Relative target from the address after the branch
	function automatic logic [15:0] ctdRel(input logic [15:0] base, input logic [7:0] disp);
		ctdRel = base + {{8{disp[7]}}, disp};
	endfunction

	// Carry combine; opcodes b0 and a0 take the complemented bit, opcodes 72 and a0 combine by OR
	function automatic logic ctdCarry(input logic [7:0] op, input logic c, input logic b);
		logic bv;
		bv = (op == `CTD_OP_ANLCNB || op == `CTD_OP_ORLCNB) ? ~b : b;
		ctdCarry = (op == `CTD_OP_ORLCB || op == `CTD_OP_ORLCNB) ? (c | bv) : (c & bv);
	endfunction

	ctd_kind_type dKind;
	ctd_reg_type dReg;
	logic [1:0] dLen;
	logic [2:0] dCyc;
	logic dDirect;
	logic dRel2;
	logic dNibble;
	logic dCarry;

	ctd_op_table uTable (
		.opcode(opcode),
		.kind(dKind),
		.regMode(dReg),
		.len(dLen),
		.cyc(dCyc),
		.usesDirect(dDirect),
		.relInByte2(dRel2),
		.nibbleOnly(dNibble),
		.carryOp(dCarry)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	ctd_state_type state, next_state;
	logic [2:0] next_cycleIndex;
	logic [2:0] next_instrCycles;
	logic next_opReady;
	logic next_busy;
	logic next_instrDone;
	logic accept;
	logic taken;

	assign accept = opValid && opReady;
	// A conditional branch pays its extra clock only when it goes
	assign taken = (dKind == KIND_COND || dKind == KIND_BITCLR) ? condTrue : (dKind != KIND_PLAIN);

	// One cycle per clock; no machine-cycle grouping, so a new opcode may enter on the last clock
	always_comb begin
		next_state = state;
		next_cycleIndex = cycleIndex;
		next_instrCycles = instrCycles;
		if (accept) begin
			next_state = ST_EXEC;
			next_cycleIndex = `CTD_CYC1;
			next_instrCycles = dCyc + {2'h0, taken && (dKind == KIND_COND || dKind == KIND_BITCLR)};
		end else begin
			case (state)
				ST_IDLE: begin
					next_cycleIndex = `CTD_RST_CYC;
				end
				ST_EXEC: begin
					if (cycleIndex == instrCycles) begin
						next_state = ST_IDLE;
						next_cycleIndex = `CTD_RST_CYC;
					end else begin
						next_cycleIndex = cycleIndex + `CTD_CYC1;
					end
				end
				default: begin
					next_state = ST_IDLE;
					next_cycleIndex = `CTD_RST_CYC;
				end
			endcase
		end
		next_busy = (next_state == ST_EXEC);
		next_instrDone = next_busy && (next_cycleIndex == next_instrCycles);
		next_opReady = !next_busy || next_instrDone;
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			cycleIndex <= `CTD_RST_CYC;
			instrCycles <= `CTD_RST_CYC;
			opReady <= 1'b1;
			busy <= 1'b0;
			instrDone <= 1'b0;
		end else begin
			state <= next_state;
			cycleIndex <= next_cycleIndex;
			instrCycles <= next_instrCycles;
			opReady <= next_opReady;
			busy <= next_busy;
			instrDone <= next_instrDone;
		end
	end

	// ----------------------------------------
	// Flow control and operands
	// ----------------------------------------
	logic [1:0] next_instrLen;
	logic next_branchTaken, next_targetValid;
	logic [15:0] next_targetAddr, next_nextAddr;
	logic next_directValid, next_directIsSfr, next_regAddrValid;
	logic [7:0] next_regAddr;
	logic next_nibbleOnly, next_clearBit, next_carryWrite, next_carryOut;
	logic [15:0] seqAddr;

	assign seqAddr = instrAddr + {14'h0, dLen};

	// Results are latched on acceptance and held for the whole instruction
	always_comb begin
		next_instrLen = instrLen;
		next_branchTaken = branchTaken;
		next_targetValid = targetValid;
		next_targetAddr = targetAddr;
		next_nextAddr = nextAddr;
		next_directValid = directValid;
		next_directIsSfr = directIsSfr;
		next_regAddrValid = regAddrValid;
		next_regAddr = regAddr;
		next_nibbleOnly = nibbleOnly;
		next_clearBit = clearBit;
		next_carryWrite = carryWrite;
		next_carryOut = carryOut;
		if (accept) begin
			next_instrLen = dLen;
			next_nextAddr = seqAddr;
			next_branchTaken = taken;
			next_targetValid = taken;
			case (dKind)
				KIND_COND, KIND_BITCLR, KIND_SHORT: begin
					next_targetAddr = ctdRel(seqAddr, dRel2 ? operand2 : operand1);
				end
				KIND_PAGE: begin
					next_targetAddr = {seqAddr[15:`CTD_PAGE_LSB], opcode[7:5], operand1};
				end
				KIND_LONG: begin
					next_targetAddr = {operand1, operand2};
				end
				KIND_INDJMP: begin
					next_targetAddr = dataPointer + {8'h00, accValue};
				end
				default: begin
					next_targetAddr = seqAddr;
				end
			endcase
			// The clear variant only clears when it actually branches
			next_clearBit = (dKind == KIND_BITCLR) && condTrue;
			next_directValid = dDirect;
			next_directIsSfr = dDirect && operand1[`CTD_SFR_BIT];
			next_regAddrValid = (dReg != REG_NONE);
			// Only R0/R1 can index; the bank bits keep registers inside the active bank
			case (dReg)
				REG_BANK: next_regAddr = {3'h0, bankSel, opcode[2:0]};
				REG_IND: next_regAddr = {3'h0, bankSel, 2'h0, opcode[0]};
				default: next_regAddr = `CTD_RST_BYTE;
			endcase
			next_nibbleOnly = dNibble;
			next_carryWrite = dCarry;
			next_carryOut = dCarry ? ctdCarry(opcode, carryIn, bitValue) : carryIn;
		end
	end

	// Flow control and operand registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			instrLen <= `CTD_RST_LEN;
			branchTaken <= 1'b0;
			targetValid <= 1'b0;
			targetAddr <= `CTD_RST_ADDR;
			nextAddr <= `CTD_RST_ADDR;
			directValid <= 1'b0;
			directIsSfr <= 1'b0;
			regAddrValid <= 1'b0;
			regAddr <= `CTD_RST_BYTE;
			nibbleOnly <= 1'b0;
			clearBit <= 1'b0;
			carryWrite <= 1'b0;
			carryOut <= 1'b0;
		end else begin
			instrLen <= next_instrLen;
			branchTaken <= next_branchTaken;
			targetValid <= next_targetValid;
			targetAddr <= next_targetAddr;
			nextAddr <= next_nextAddr;
			directValid <= next_directValid;
			directIsSfr <= next_directIsSfr;
			regAddrValid <= next_regAddrValid;
			regAddr <= next_regAddr;
			nibbleOnly <= next_nibbleOnly;
			clearBit <= next_clearBit;
			carryWrite <= next_carryWrite;
			carryOut <= next_carryOut;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_acc_one;
		accept && (opcode == `CTD_OP_SWAPA || opcode == `CTD_OP_RRCA) |=> instrLen == 2'h1 && instrCycles == 3'h1;
	endproperty
	a_acc_one: assert property (p_acc_one) else $error("accumulator op not one cycle");

	property p_ind_load;
		accept && opcode[7:1] == 7'h73 |=> instrCycles == 3'h2 && regAddr == {3'h0, $past(bankSel), 2'h0, $past(opcode[0])};
	endproperty
	a_ind_load: assert property (p_ind_load) else $error("indirect load timing or index wrong");

	property p_long_four;
		accept && opcode == `CTD_OP_LONGJUMP |=> !instrDone [*3] ##1 instrDone && targetAddr == {$past(operand1, 4), $past(operand2, 4)};
	endproperty
	a_long_four: assert property (p_long_four) else $error("long jump not four cycles");

	property p_zero_branch;
		accept && opcode == `CTD_OP_JZ |=> instrCycles == ($past(condTrue) ? 3'h3 : 3'h2);
	endproperty
	a_zero_branch: assert property (p_zero_branch) else $error("zero branch cycle count wrong");

	property p_cmp_ind;
		accept && opcode[7:1] == 7'h5b |=> instrLen == 2'h3 && instrCycles == ($past(condTrue) ? 3'h5 : 3'h4);
	endproperty
	a_cmp_ind: assert property (p_cmp_ind) else $error("indirect compare branch timing wrong");

	property p_bit_clear;
		accept && opcode == `CTD_OP_BITCLR |=> clearBit == $past(condTrue) && instrCycles == ($past(condTrue) ? 3'h4 : 3'h3);
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit clear branch wrong");

	property p_short_rel;
		accept && opcode == `CTD_OP_SHORTJ |=> targetAddr == $past(instrAddr) + 16'h2 + {{8{$past(operand1[7])}}, $past(operand1)};
	endproperty
	a_short_rel: assert property (p_short_rel) else $error("relative target wrong");

	property p_page;
		accept && opcode[3:0] == 4'h1 |=> targetAddr[15:11] == $past(seqAddr[15:11]) && targetAddr[10:8] == $past(opcode[7:5]);
	endproperty
	a_page: assert property (p_page) else $error("page target left its page");

	property p_sfr;
		accept && opcode == `CTD_OP_PUSH |=> directIsSfr == $past(operand1[7]) && instrCycles == 3'h2;
	endproperty
	a_sfr: assert property (p_sfr) else $error("direct space select wrong");

	property p_unused;
		accept && opcode == `CTD_OP_UNUSED |=> instrCycles == 3'h1 && !targetValid && !clearBit && !regAddrValid;
	endproperty
	a_unused: assert property (p_unused) else $error("unused opcode not a no-op");

	property p_count;
		busy && cycleIndex != instrCycles |=> busy && cycleIndex == $past(cycleIndex) + 3'h1;
	endproperty
	a_count: assert property (p_count) else $error("cycle counter did not advance");

	c_taken_cmp: cover property (accept && opcode == `CTD_OP_CMPAD && condTrue ##4 instrDone);
	c_back_to_back: cover property (instrDone && accept);
	c_page_call: cover property (accept && opcode[4:0] == 5'h11);
	c_nibble: cover property (accept && opcode[7:1] == 7'h6b ##1 nibbleOnly);
endmodule

// ---- verification/ctd_timing_decoder_bench.sv ----
// Self-checking bench of the instruction timing decoder
`timescale 1ns/1ps
`include "ctd_map.svh"
module ctd_timing_decoder_bench;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic mclk, nrst, opValid, condTrue, carryIn, bitValue;
	logic [7:0] opcode, operand1, operand2, accValue;
	logic [1:0] bankSel, instrLen;
	logic [15:0] instrAddr, dataPointer, targetAddr, nextAddr;
	logic opReady, busy, instrDone, branchTaken, targetValid, directValid, directIsSfr;
	logic regAddrValid, nibbleOnly, clearBit, carryWrite, carryOut;
	logic [2:0] cycleIndex, instrCycles;
	logic [7:0] regAddr;
	logic [31:0] seed;
	logic [31:0] r;
	int fails, nTests;
	// Page-edge and wrap addresses where target arithmetic is most fragile
	logic [15:0] corner [4] = '{16'h07fe, 16'hfffe, 16'h0000, 16'h7ffd};

	ctd_timing_decoder i_dut (.mclk(mclk), .nrst(nrst), .opValid(opValid), .opcode(opcode), .operand1(operand1),
		.operand2(operand2), .instrAddr(instrAddr), .condTrue(condTrue), .bankSel(bankSel), .accValue(accValue),
		.dataPointer(dataPointer), .carryIn(carryIn), .bitValue(bitValue), .opReady(opReady), .busy(busy),
		.instrDone(instrDone), .cycleIndex(cycleIndex), .instrCycles(instrCycles), .instrLen(instrLen),
		.branchTaken(branchTaken), .targetValid(targetValid), .targetAddr(targetAddr), .nextAddr(nextAddr),
		.directValid(directValid), .directIsSfr(directIsSfr), .regAddrValid(regAddrValid), .regAddr(regAddr),
		.nibbleOnly(nibbleOnly), .clearBit(clearBit), .carryWrite(carryWrite), .carryOut(carryOut));

	// Free-running 250 MHz clock
	always #2 mclk = ~mclk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Galois shift register so every run draws the same sequence
	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
		return seed;
	endfunction

	// Case equality, so an unknown output never counts as a match
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reportAndStop();
		if (fails == 0 && nTests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Length, clock count and kind of flow change (0 none, 1 cond, 2 short, 3 page, 4 long, 5 indirect)
	function automatic void expect_op(input logic [7:0] op, input logic c, output logic [1:0] l,
		output logic [2:0] n, output logic [2:0] k);
		l = 2'h1;
		n = 3'h1;
		k = 3'h0;
		case (op)
			`CTD_OP_MOVDD, `CTD_OP_LOADDP, `CTD_OP_XRLDI: begin l = 2'h3; n = 3'h3; end
			`CTD_OP_CODEDP, `CTD_OP_CODEPC, `CTD_OP_EXTRDDP, `CTD_OP_EXTWRDP: n = 3'h3;
			`CTD_OP_PUSH, `CTD_OP_POP, `CTD_OP_ANLCB, `CTD_OP_ANLCNB, `CTD_OP_ORLCB, `CTD_OP_ORLCNB: begin
				l = 2'h2;
				n = 3'h2;
			end
			`CTD_OP_JZ, `CTD_OP_JNZ, `CTD_OP_JC, `CTD_OP_JNC: begin l = 2'h2; n = 3'h2 + {2'h0, c}; k = 3'h1; end
			`CTD_OP_JB, `CTD_OP_JNB, `CTD_OP_BITCLR, `CTD_OP_CMPAD, `CTD_OP_CMPAI, `CTD_OP_DECDIR: begin
				l = 2'h3;
				n = 3'h3 + {2'h0, c};
				k = 3'h1;
			end
			`CTD_OP_SHORTJ: begin l = 2'h2; n = 3'h3; k = 3'h2; end
			`CTD_OP_INDJMP: begin n = 3'h3; k = 3'h5; end
			`CTD_OP_LONGCALL, `CTD_OP_LONGJUMP: begin l = 2'h3; n = 3'h4; k = 3'h4; end
			default: begin
				if (op[3:0] == `CTD_LO4_PAGE) begin l = 2'h2; n = 3'h3; k = 3'h3; end
				else if (op[7:3] == `CTD_HI5_CMPRN) begin l = 2'h3; n = 3'h3 + {2'h0, c}; k = 3'h1; end
				else if (op[7:3] == `CTD_HI5_DECRN) begin l = 2'h2; n = 3'h2 + {2'h0, c}; k = 3'h1; end
				else if (op[7:1] == `CTD_HI7_CMPIND) begin l = 2'h3; n = 3'h4 + {2'h0, c}; k = 3'h1; end
				else if (op[7:1] == `CTD_HI7_MOVAIND || op[7:1] == `CTD_HI7_NIBXCH) n = 3'h2;
				else if (op[7:1] == `CTD_HI7_EXTRDI || op[7:1] == `CTD_HI7_EXTWRI) n = 3'h3;
			end
		endcase
	endfunction

	// ----------------------------------------
	// One instruction, accepted and walked to completion
	// ----------------------------------------
	task automatic run_op(input logic [7:0] op, input logic c, input logic [15:0] a);
		logic [1:0] l, bk;
		logic [2:0] n, k;
		logic [7:0] o1, o2, ac, rel;
		logic [15:0] dp, nx, tg;
		logic ci, bv, tk, dv, rv, cw, co;
		logic [31:0] q;
		int w;
		q = lfsr();
		{o1, o2, ac, bk, ci, bv} = q[27:0];
		q = lfsr();
		dp = q[15:0];
		expect_op(op, c, l, n, k);
		nx = a + {14'h0, l};
		rel = (l == 2'h3) ? o2 : o1;
		tk = (k == 3'h1) ? c : (k != 3'h0);
		case (k)
			3'h1, 3'h2: tg = nx + {{8{rel[7]}}, rel};
			3'h3: tg = {nx[15:11], op[7:5], o1};
			3'h4: tg = {o1, o2};
			3'h5: tg = dp + {8'h0, ac};
			default: tg = nx;
		endcase
		dv = op inside {`CTD_OP_PUSH, `CTD_OP_POP, `CTD_OP_MOVDD, `CTD_OP_XRLDI, `CTD_OP_CMPAD, `CTD_OP_DECDIR};
		rv = op[7:3] inside {`CTD_HI5_MOVARN, `CTD_HI5_CMPRN, `CTD_HI5_DECRN};
		cw = 1'b1;
		case (op)
			`CTD_OP_ANLCB: co = ci & bv;
			`CTD_OP_ANLCNB: co = ci & ~bv;
			`CTD_OP_ORLCB: co = ci | bv;
			`CTD_OP_ORLCNB: co = ci | ~bv;
			default: begin cw = 1'b0; co = ci; end
		endcase
		opcode = op;
		operand1 = o1;
		operand2 = o2;
		instrAddr = a;
		condTrue = c;
		accValue = ac;
		bankSel = bk;
		dataPointer = dp;
		carryIn = ci;
		bitValue = bv;
		opValid = 1'b1;
		w = 0;
		while (opReady !== 1'b1 && w < 8) begin @(negedge mclk); w++; end
		chk(opReady, 1'b1);
		@(negedge mclk);
		// Junk offered while busy must be refused and must not disturb the held outputs
		if (n > 3'h1) begin
			q = lfsr();
			opValid = q[0];
			{opcode, operand1, operand2} = q[31:8];
		end
		chk({instrLen, instrCycles}, {l, n});
		chk({branchTaken, targetValid}, {tk, tk});
		chk(targetAddr, tg);
		chk(nextAddr, nx);
		chk({nibbleOnly, clearBit}, {op[7:1] == `CTD_HI7_NIBXCH, op == `CTD_OP_BITCLR && c});
		if (dv) chk({directValid, directIsSfr}, {1'b1, o1[7]});
		if (rv) chk({regAddrValid, regAddr}, {1'b1, 3'h0, bk, op[2:0]});
		if (op[7:1] inside {`CTD_HI7_MOVAIND, `CTD_HI7_NIBXCH, `CTD_HI7_CMPIND, `CTD_HI7_EXTRDI, `CTD_HI7_EXTWRI})
			chk({regAddrValid, regAddr}, {1'b1, 3'h0, bk, 2'h0, op[0]});
		if (cw) chk({carryWrite, carryOut}, {1'b1, co});
		if (op == `CTD_OP_NOP || op == `CTD_OP_UNUSED)
			chk({carryWrite, carryOut, clearBit, nibbleOnly, directValid, regAddrValid, branchTaken}, {1'b0, ci, 5'h0});
		for (int i = 1; i <= n; i++) begin
			chk({busy, cycleIndex, instrDone, opReady}, {1'b1, 3'(i), i == n, i == n});
			if (i < n) @(negedge mclk);
		end
		chk({instrCycles, targetAddr}, {n, tg});
	endtask

	// Quiet spell after an instruction; the decoder must fall idle
	task automatic idle(input int g);
		opValid = 1'b0;
		repeat (g) @(negedge mclk);
		chk({busy, instrDone, cycleIndex}, 5'h0);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		{opValid, condTrue, carryIn, bitValue} = 4'h0;
		{opcode, operand1, operand2, accValue, bankSel} = 34'h0;
		{instrAddr, dataPointer} = 32'h0;
		fails = 0;
		nTests = 0;
		seed = 32'h59a9e091;
		repeat (12) @(negedge mclk);
		chk({opReady, busy, instrDone, cycleIndex, targetValid}, 7'h40);
		nrst = 1'b1;
		// Every opcode, both branch outcomes, random then corner addresses, often back to back
		for (int p = 0; p < 4; p++) begin
			for (int o = 0; o < 256; o++) begin
				r = lfsr();
				run_op(8'(o), p[0], p[1] ? corner[r[1:0]] : r[31:16]);
				if (r[4:2] == 3'h0) idle(int'(r[6:5]) + 1);
			end
		end
		for (int j = 0; j < 600; j++) begin
			r = lfsr();
			run_op(r[7:0], r[8], r[31:16]);
			if (r[11:9] == 3'h0) idle(1);
		end
		// Reset in the middle of a long call clears the count
		run_op(`CTD_OP_LONGJUMP, 1'b0, 16'h1234);
		// Offer the call explicitly; junk left by the previous long jump must not decide which opcode is offered
		opcode = `CTD_OP_LONGCALL;
		opValid = 1'b1;
		@(negedge mclk);
		chk({busy, cycleIndex, instrCycles}, {1'b1, 3'h1, 3'h4});
		opValid = 1'b0;
		nrst = 1'b0;
		@(negedge mclk);
		chk({opReady, busy, instrDone, cycleIndex, branchTaken}, 7'h40);
		nrst = 1'b1;
		idle(1);
		run_op(`CTD_OP_UNUSED, 1'b1, 16'hffff);
		idle(2);
		reportAndStop();
	end

	// Watchdog well beyond the expected run of some three thousand cycles
	initial begin
		repeat (40000) @(posedge mclk);
		fails++;
		reportAndStop();
	end
endmodule
